// ### verilog/clft_pkg.sv
/*
 * Shared constants and types of the courtesy lamp fade timer.
 * Assumes one 200 MHz clock; lamp timers and fade steps run on a 1 ms tick, the PWM on the clock.
 */
package clft_pkg;

  // ---------------------------------------------------------------
  // Clock and tick
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned TICK_TIME_NS    = 1000000;
  localparam int unsigned TICK_CYCLES_DEF = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Lamp times, in their own units, then in ticks
  // ---------------------------------------------------------------
  localparam int unsigned LONG_ON_MIN    = 20;
  localparam int unsigned SHORT_ON_S     = 30;
  localparam int unsigned INHIBIT_S      = 1;
  localparam int unsigned DOOR_QUAL_MS   = 100;
  localparam int unsigned FADE_MS        = 2000;
  localparam int unsigned LONG_ON_TICKS  = LONG_ON_MIN * 60 * 1000;
  localparam int unsigned SHORT_ON_TICKS = SHORT_ON_S * 1000;
  localparam int unsigned INHIBIT_TICKS  = INHIBIT_S * 1000;
  // One tick more than the figure, so that the door is open for over it
  localparam int unsigned DOOR_QUAL_TICKS = DOOR_QUAL_MS + 1;

  // ---------------------------------------------------------------
  // Fade, PWM and counter widths
  // ---------------------------------------------------------------
  localparam logic [7:0]  DUTY_FULL       = 8'hfa;
  localparam int unsigned FADE_STEP_TICKS = FADE_MS / 250;
  localparam int unsigned TMR_W           = 21;
  localparam int unsigned QUAL_W          = 8;
  localparam int unsigned INH_W           = 11;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0]  CTRL_OFS   = 4'h0;
  localparam logic [3:0]  STATUS_OFS = 4'h4;
  localparam logic [1:0]  CTRL_RST   = 2'h3;

  typedef enum logic [2:0] {
    LAMP_OFF,
    LAMP_ON30,
    LAMP_ON20,
    LAMP_DECAY,
    LAMP_ON_UNL
  } clft_lamp_state_t;

endpackage : clft_pkg

// ### verilog/clft_lamp_if.sv
/*
 * Link between a lamp state machine and its fade generator.
 * Assumes both ends share the block clock.
 */
interface clft_lamp_if;
  logic       hold_on;
  logic       fade_start;
  logic [7:0] duty;
  logic       fade_done;
  logic       lamp_drive;

  modport ctl  (output hold_on, output fade_start, input duty, input fade_done, input lamp_drive);
  modport fade (input hold_on, input fade_start, output duty, output fade_done, output lamp_drive);
endinterface : clft_lamp_if

// ### verilog/clft_fade.sv
/*
 * Fade generator: full drive on hold, a stepped ramp to dark on start,
 * and a PWM output from the current duty.
 * Assumes a one-cycle tick and a synchronous active-high reset.
 */
module clft_fade
  import clft_pkg::*;
#(
  parameter int unsigned STEP_TICKS = FADE_STEP_TICKS
) (
  // Clock, reset and tick
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic tick,
  // Lamp link
  clft_lamp_if.fade lnk
);

  generate
    if (STEP_TICKS < 1 || STEP_TICKS > 255) begin : g_chk
      $error("clft_fade: STEP_TICKS out of range");
    end
  endgenerate

  logic [7:0] duty_reg, duty_next;
  logic [7:0] step_reg, step_next;
  logic [7:0] pwm_reg,  pwm_next;
  logic       fading_reg, fading_next;
  logic       done_reg, done_next;
  logic       drive_reg, drive_next;

  always_comb begin
    duty_next   = duty_reg;
    step_next   = step_reg;
    fading_next = fading_reg;
    done_next   = 1'b0;
    // Start wins over hold: it comes while the machine still shows an on state
    if (lnk.fade_start) begin
      duty_next   = DUTY_FULL;
      step_next   = 8'h00;
      fading_next = 1'b1;
    end else if (lnk.hold_on) begin
      duty_next   = DUTY_FULL;
      fading_next = 1'b0;
    end else if (fading_reg) begin
      if (tick) begin
        if (step_reg == 8'(STEP_TICKS - 1)) begin
          step_next = 8'h00;
          duty_next = duty_reg - 8'h01; // R21
          if (duty_reg == 8'h01) begin
            fading_next = 1'b0;
            done_next   = 1'b1; // R21
          end
        end else begin
          step_next = step_reg + 8'h01;
        end
      end
    end else begin
      duty_next = 8'h00;
    end
    pwm_next   = (pwm_reg == DUTY_FULL - 8'h01) ? 8'h00 : pwm_reg + 8'h01;
    drive_next = pwm_reg < duty_reg;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      duty_reg   <= 8'h00;
      step_reg   <= 8'h00;
      pwm_reg    <= 8'h00;
      fading_reg <= 1'b0;
      done_reg   <= 1'b0;
      drive_reg  <= 1'b0;
    end else begin
      duty_reg   <= duty_next;
      step_reg   <= step_next;
      pwm_reg    <= pwm_next;
      fading_reg <= fading_next;
      done_reg   <= done_next;
      drive_reg  <= drive_next;
    end
  end

  assign lnk.duty       = duty_reg;
  assign lnk.fade_done  = done_reg;
  assign lnk.lamp_drive = drive_reg;

  a_fade_mono: assert property (@(posedge mclk) disable iff (sys_rst) // R21
    fading_reg && !lnk.fade_start && !lnk.hold_on |=> duty_reg <= $past(duty_reg))
    else $error("fade duty rose while fading");

endmodule : clft_fade

// ### verilog/clft_lamp_ctrl.sv
/*
 * Room and foot courtesy lamp controller with timed on states and fades,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes all inputs synchronous to mclk; unlock inputs are one-cycle pulses.
 */
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
// Behaviour
// R1: Room 20-minute on, ignition turns on: go unlimited on, no timeout.
// R2: Room 20-minute, ignition off, all unlocked, doors all close: go 30-second on.
// R3: Room 20-minute, ignition off: closed and locked, or timeout, starts the fade.
// R4: Room fading, ignition off: door qualified open returns to 20-minute on.
// R5: Room fading, ignition off, doors closed: any remote unlock gives 30-second on.
// R6: Room fade finished: room lamp goes off, fully dark.
// R7: Room fading: ignition on with a door open gives unlimited on.
// R8: Room unlimited on: all doors closing starts the fade.
// R9: Room unlimited on: ignition off gives 20-minute on.
// R10: Room unlimited on: doors closed with ignition off gives 30-second on, timer cleared.
// R11: Foot off, ignition off: door qualified open gives 20-minute on.
// R12: Foot off, ignition off, closed: keyless or smart key unlock gives 30-second on.
// R13: Foot off: ignition on with door open or park gives unlimited on.
// R14: Foot 30-second, ignition off: door qualified open gives 20-minute on.
// R15: Foot 30-second, ignition off: keyless or smart key unlock restarts the timer.
// R16: Foot 30-second: ignition on out of park after inhibit, timeout, alarm or lock fades.
// R17: All doors count as locked only when all four knob-unlocked flags are zero.
// R18: Room off, ignition off: door qualified open gives 20-minute on.
// R19: Room 30-second: ignition on, timeout, alarm armed or all locked starts the fade.
// R20: A door counts as opened only after staying open past the qualification time.
// R21: The fade lowers duty steadily to zero, then signals completion.
module clft_lamp_ctrl
  import clft_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned LONG_TICKS  = LONG_ON_TICKS,
  parameter int unsigned SHORT_TICKS = SHORT_ON_TICKS,
  parameter int unsigned INH_TICKS   = INHIBIT_TICKS,
  parameter int unsigned QUAL_TICKS  = DOOR_QUAL_TICKS,
  parameter int unsigned STEP_TICKS  = FADE_STEP_TICKS
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Vehicle inputs
  input  wire logic        ignition_run_input,
  input  wire logic        any_door_open,
  input  wire logic [3:0]  door_knob_unlocked_flag,
  input  wire logic        remote_keyless_unlock,
  input  wire logic        telematics_unlock_source,
  input  wire logic        smart_key_unlock,
  input  wire logic        smart_key_variant,
  input  wire logic        park_position,
  input  wire logic        alarm_armed_flag,
  // Lamp outputs
  output logic             room_lamp_drive,
  output logic             foot_lamp_drive,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

  generate
    if (TICK_CYCLES < 1 || LONG_TICKS >= (1 << TMR_W) || SHORT_TICKS >= (1 << TMR_W) ||
        INH_TICKS >= (1 << INH_W) || QUAL_TICKS >= (1 << QUAL_W) || QUAL_TICKS < 1) begin : g_chk
      $error("clft_lamp_ctrl: timing parameter out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Millisecond tick, door qualification, park-release inhibit
  // ---------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic              tick_reg, tick_next;
  logic [QUAL_W-1:0] qual_reg, qual_next;
  logic              door_q_reg, door_q_next;
  logic              door_qd_reg, door_qd_next;
  logic [INH_W-1:0]  inh_reg, inh_next;
  logic              door_rise;
  logic              inhib_done;
  logic              all_locked;
  logic              all_unlocked;
  logic              unl_key;
  logic              unl_any;

  always_comb begin
    tick_next     = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);
    tick_cnt_next = tick_next ? '0 : tick_cnt_reg + TICK_W'(1);
    qual_next     = qual_reg;
    // A short opening is forgotten at once; only a continuous opening counts
    if (!any_door_open) begin
      qual_next = '0; // R20
    end else if (tick_reg && qual_reg != QUAL_W'(QUAL_TICKS)) begin
      qual_next = qual_reg + QUAL_W'(1); // R20
    end
    door_q_next  = any_door_open && (qual_reg == QUAL_W'(QUAL_TICKS)); // R20
    door_qd_next = door_q_reg;
    inh_next     = inh_reg;
    if (!ignition_run_input) begin
      inh_next = '0;
    end else if (tick_reg && inh_reg != INH_W'(INH_TICKS)) begin
      inh_next = inh_reg + INH_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
      qual_reg     <= '0;
      door_q_reg   <= 1'b0;
      door_qd_reg  <= 1'b0;
      inh_reg      <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
      qual_reg     <= qual_next;
      door_q_reg   <= door_q_next;
      door_qd_reg  <= door_qd_next;
      inh_reg      <= inh_next;
    end
  end

  assign door_rise    = door_q_reg && !door_qd_reg;
  assign inhib_done   = inh_reg == INH_W'(INH_TICKS);
  assign all_locked   = door_knob_unlocked_flag == 4'h0; // R17
  assign all_unlocked = door_knob_unlocked_flag == 4'hf;
  assign unl_key      = remote_keyless_unlock || (smart_key_variant && smart_key_unlock);
  assign unl_any      = unl_key || telematics_unlock_source;

  // ---------------------------------------------------------------
  // Lamp state machines (index 0 room, 1 foot)
  // ---------------------------------------------------------------
  function automatic clft_lamp_state_t lamp_next(input clft_lamp_state_t cur, input logic foot,
                                                 input logic expired, input logic done);
    logic ign;
    logic open;
    logic park;
    ign  = ignition_run_input;
    open = any_door_open;
    park = foot && park_position;
    lamp_next = cur;
    unique case (cur)
      LAMP_OFF: begin
        if (ign && (open || park)) lamp_next = LAMP_ON_UNL; // R13
        else if (!ign && door_rise) lamp_next = LAMP_ON20; // R11 R18
        else if (!ign && !open && unl_key) lamp_next = LAMP_ON30; // R12
      end
      LAMP_ON30: begin
        if (!ign && door_q_reg) lamp_next = LAMP_ON20; // R14
        else if (!ign && unl_key) lamp_next = LAMP_ON30; // R15
        else if (ign && park && inhib_done) lamp_next = LAMP_ON_UNL;
        else if ((ign && (!foot || (!park && inhib_done))) || expired || alarm_armed_flag || all_locked)
          lamp_next = LAMP_DECAY; // R16 R19
      end
      LAMP_ON20: begin
        if (ign) lamp_next = LAMP_ON_UNL; // R1
        else if (!open && all_unlocked) lamp_next = LAMP_ON30; // R2
        else if ((!open && all_locked) || expired) lamp_next = LAMP_DECAY; // R3
      end
      LAMP_DECAY: begin
        if (ign && (open || park)) lamp_next = LAMP_ON_UNL; // R7
        else if (done) lamp_next = LAMP_OFF; // R6
        else if (!ign && door_rise) lamp_next = LAMP_ON20; // R4
        else if (!ign && !open && unl_any) lamp_next = LAMP_ON30; // R5
      end
      LAMP_ON_UNL: begin
        if (!open && !ign) lamp_next = LAMP_ON30; // R10
        else if (!open && !park) lamp_next = LAMP_DECAY; // R8
        else if (!ign) lamp_next = LAMP_ON20; // R9
      end
      default: lamp_next = LAMP_OFF;
    endcase
  endfunction

  logic [1:0]        ctrl_reg, ctrl_next;
  clft_lamp_state_t  st_reg  [2];
  clft_lamp_state_t  st_next [2];
  logic [TMR_W-1:0]  tmr_reg [2];
  logic [TMR_W-1:0]  tmr_next[2];
  logic [1:0]        expired;
  logic [1:0]        restart;
  logic [1:0]        drive;
  logic [7:0]        duty  [2];

  clft_lamp_if lamp_lnk[2] ();

  for (genvar i = 0; i < 2; i++) begin : g_lamp
    logic [TMR_W-1:0] limit;

    assign limit      = (st_reg[i] == LAMP_ON20) ? TMR_W'(LONG_TICKS) : TMR_W'(SHORT_TICKS);
    assign expired[i] = ((st_reg[i] == LAMP_ON20) || (st_reg[i] == LAMP_ON30)) && (tmr_reg[i] >= limit);

    always_comb begin
      st_next[i]  = ctrl_reg[i] ? lamp_next(st_reg[i], i == 1, expired[i], lamp_lnk[i].fade_done) : LAMP_OFF;
      restart[i]  = (st_reg[i] == LAMP_ON30) && !ignition_run_input && unl_key && !door_q_reg; // R15
      tmr_next[i] = tmr_reg[i];
      // Any change of state starts the new state's timer from zero
      if (st_next[i] != st_reg[i] || restart[i]) begin
        tmr_next[i] = '0; // R10 R15
      end else if (tick_reg && !expired[i]) begin
        tmr_next[i] = tmr_reg[i] + TMR_W'(1);
      end
    end

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        st_reg[i]  <= LAMP_OFF;
        tmr_reg[i] <= '0;
      end else begin
        st_reg[i]  <= st_next[i];
        tmr_reg[i] <= tmr_next[i];
      end
    end

    assign lamp_lnk[i].fade_start = (st_next[i] == LAMP_DECAY) && (st_reg[i] != LAMP_DECAY); // R3 R8 R16 R19
    assign lamp_lnk[i].hold_on    = (st_reg[i] == LAMP_ON20) || (st_reg[i] == LAMP_ON30) ||
                                    (st_reg[i] == LAMP_ON_UNL);
    assign drive[i]               = lamp_lnk[i].lamp_drive;
    assign duty[i]                = lamp_lnk[i].duty;

    clft_fade #(.STEP_TICKS(STEP_TICKS)) u_fade (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .tick    (tick_reg),
      .lnk     (lamp_lnk[i])
    );
  end

  assign room_lamp_drive = drive[0];
  assign foot_lamp_drive = drive[1];

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ---------------------------------------------------------------
  logic        ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;

  always_comb begin
    ack_next   = (avs_read || avs_write) && !ack_reg;
    rdata_next = rdata_reg;
    ctrl_next  = ctrl_reg;
    if (avs_read && !ack_reg) begin
      unique case (avs_address)
        CTRL_OFS:   rdata_next = {30'h0, ctrl_reg};
        STATUS_OFS: rdata_next = {5'h0, all_locked, inhib_done, door_q_reg, duty[1], duty[0],
                                  1'b0, st_reg[1], 1'b0, st_reg[0]};
        default:    rdata_next = 32'h0;
      endcase
    end
    if (avs_write && ack_reg && avs_address == CTRL_OFS && avs_byteenable[0]) begin
      ctrl_next = avs_writedata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
      ctrl_reg  <= CTRL_RST;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      ctrl_reg  <= ctrl_next;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata    = rdata_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_room(clft_lamp_state_t s);
    ctrl_reg[0] && st_reg[0] == s;
  endsequence

  sequence s_foot(clft_lamp_state_t s);
    ctrl_reg[1] && st_reg[1] == s;
  endsequence

  a_room_ign_unl: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    s_room(LAMP_ON20) ##0 ignition_run_input |=> st_reg[0] == LAMP_ON_UNL)
    else $error("room 20-minute did not go unlimited");
  a_room_close30: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    s_room(LAMP_ON20) ##0 (!ignition_run_input && !any_door_open && door_knob_unlocked_flag == 4'hf)
    |=> st_reg[0] == LAMP_ON30 ##0 tmr_reg[0] == '0)
    else $error("room 20-minute did not go 30-second");
  a_room_expire: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    s_room(LAMP_ON20) ##0 (!ignition_run_input && tmr_reg[0] >= TMR_W'(LONG_TICKS))
    |=> st_reg[0] == LAMP_DECAY ##1 lamp_lnk[0].duty == DUTY_FULL)
    else $error("room timeout did not start the fade");
  a_room_door20: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    s_room(LAMP_DECAY) ##0 (!ignition_run_input && door_rise && !lamp_lnk[0].fade_done)
    |=> st_reg[0] == LAMP_ON20)
    else $error("room fade not ended by door");
  a_room_unlock: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    s_room(LAMP_DECAY) ##0 (!ignition_run_input && !any_door_open && telematics_unlock_source &&
    !lamp_lnk[0].fade_done && !door_rise) |=> st_reg[0] == LAMP_ON30)
    else $error("room fade not ended by unlock");
  a_room_dark: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    s_room(LAMP_DECAY) ##0 (lamp_lnk[0].fade_done && !ignition_run_input)
    |=> st_reg[0] == LAMP_OFF ##0 lamp_lnk[0].duty == 8'h00 ##2 !room_lamp_drive)
    else $error("room lamp not dark after fade");
  a_room_relight: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    s_room(LAMP_DECAY) ##0 (ignition_run_input && any_door_open) |=> st_reg[0] == LAMP_ON_UNL)
    else $error("room fade not ended by ignition");
  a_unl_close: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    s_room(LAMP_ON_UNL) ##0 (ignition_run_input && !any_door_open) |=> st_reg[0] == LAMP_DECAY)
    else $error("room unlimited did not fade on close");
  a_unl_ignoff: assert property (@(posedge mclk) disable iff (sys_rst) // R9
    s_room(LAMP_ON_UNL) ##0 (!ignition_run_input && any_door_open) |=> st_reg[0] == LAMP_ON20)
    else $error("room unlimited did not go 20-minute");
  a_unl_to30: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    s_room(LAMP_ON_UNL) ##0 (!ignition_run_input && !any_door_open)
    |=> st_reg[0] == LAMP_ON30 ##0 tmr_reg[0] == '0)
    else $error("room unlimited did not go 30-second");
  a_foot_door: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    s_foot(LAMP_OFF) ##0 (!ignition_run_input && door_rise) |=> st_reg[1] == LAMP_ON20)
    else $error("foot off not lit by door");
  a_foot_unlock: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    s_foot(LAMP_OFF) ##0 (!ignition_run_input && !any_door_open && remote_keyless_unlock)
    |=> st_reg[1] == LAMP_ON30)
    else $error("foot off not lit by unlock");
  a_foot_ign: assert property (@(posedge mclk) disable iff (sys_rst) // R13
    s_foot(LAMP_OFF) ##0 (ignition_run_input && (any_door_open || park_position))
    |=> st_reg[1] == LAMP_ON_UNL)
    else $error("foot off not lit by ignition");
  a_foot_door20: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    s_foot(LAMP_ON30) ##0 (!ignition_run_input && door_q_reg) |=> st_reg[1] == LAMP_ON20)
    else $error("foot 30-second not extended by door");
  a_foot_restart: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    s_foot(LAMP_ON30) ##0 (!ignition_run_input && !door_q_reg && remote_keyless_unlock)
    |=> st_reg[1] == LAMP_ON30 ##0 tmr_reg[1] == '0)
    else $error("foot 30-second timer not restarted");
  a_foot_fade: assert property (@(posedge mclk) disable iff (sys_rst) // R16 R17
    s_foot(LAMP_ON30) ##0 (!ignition_run_input && !unl_key && !door_q_reg && door_knob_unlocked_flag == 4'h0)
    |=> st_reg[1] == LAMP_DECAY)
    else $error("foot 30-second not faded on lock");
  a_room_off_door: assert property (@(posedge mclk) disable iff (sys_rst) // R18
    s_room(LAMP_OFF) ##0 (!ignition_run_input && door_rise) |=> st_reg[0] == LAMP_ON20)
    else $error("room off not lit by door");
  a_room30_alarm: assert property (@(posedge mclk) disable iff (sys_rst) // R19
    s_room(LAMP_ON30) ##0 (alarm_armed_flag && !door_q_reg && !unl_key) |=> st_reg[0] == LAMP_DECAY)
    else $error("room 30-second not faded on alarm");
  a_door_filter: assert property (@(posedge mclk) disable iff (sys_rst) // R20
    $rose(door_q_reg) |-> $past(any_door_open, 1) && $past(qual_reg, 1) == QUAL_W'(QUAL_TICKS))
    else $error("door qualified too early");

endmodule : clft_lamp_ctrl

// ### test/clft_vehicle.sv
/*
 * Vehicle side model: ignition, doors, knobs, park, alarm and unlock pulses.
 * Assumes the bench calls apply() from one thread; unlocks last one cycle.
 */
module clft_vehicle (
  // Clock
  input  wire logic  mclk,
  // Vehicle levels
  output logic       ignition,
  output logic       door,
  output logic [3:0] knobs,
  output logic       park,
  output logic       alarm,
  // Unlock pulses
  output logic       keyless,
  output logic       telem,
  output logic       skey
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {ignition, door, park, alarm, keyless, telem, skey} = 7'h00;
    knobs = 4'hf;
  end

  // Levels change together; unlock pulses drop after one cycle
  task automatic apply(input logic [3:0] f, input logic [3:0] k, input logic [2:0] u);
    @(posedge mclk);
    {ignition, door, park, alarm} <= f;
    knobs <= k;
    {skey, telem, keyless} <= u;
    @(posedge mclk);
    {skey, telem, keyless} <= 3'h0;
  endtask : apply
endmodule : clft_vehicle

// ### test/courtesy_lamp_fade_timer_tb.sv
/*
 * Self-checking bench: vehicle steps, then STATUS reads over Avalon-MM.
 * Assumes shortened timers: 2-cycle tick, fade of 500 cycles.
 */
module courtesy_lamp_fade_timer_tb;
  import clft_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        skv = 1'b1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        room_lamp_drive;
  logic        foot_lamp_drive;
  wire logic   ignition, door, park, alarm, keyless, telem, skey;
  wire logic [3:0] knobs;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [31:0] rd;

  always #2.5 mclk = ~mclk;

  clft_vehicle veh_u (.mclk(mclk), .ignition(ignition), .door(door), .knobs(knobs), .park(park),
    .alarm(alarm), .keyless(keyless), .telem(telem), .skey(skey));

  clft_lamp_ctrl #(.TICK_CYCLES(2), .LONG_TICKS(200), .SHORT_TICKS(60),
    .QUAL_TICKS(3), .STEP_TICKS(1)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .ignition_run_input(ignition), .any_door_open(door), .door_knob_unlocked_flag(knobs),
    .remote_keyless_unlock(keyless), .telematics_unlock_source(telem), .smart_key_unlock(skey),
    .smart_key_variant(skv), .park_position(park), .alarm_armed_flag(alarm),
    .room_lamp_drive(room_lamp_drive), .foot_lamp_drive(foot_lamp_drive),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  task automatic final_report();
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Flags are {ignition, door, park, alarm}; unlocks are {smart key, telematics, keyless}
  task automatic st(input logic [3:0] f, input logic [3:0] k, input logic [2:0] u, input int w,
                    input logic [2:0] er, input logic [2:0] ef);
    veh_u.apply(f, k, u);
    repeat (w) @(posedge mclk);
    bus(1'b0, STATUS_OFS, 32'h0, rd);
    chk("room_state", {29'h0, er}, {29'h0, rd[2:0]});
    chk("foot_state", {29'h0, ef}, {29'h0, rd[6:4]});
    if (er != 3'h3) chk("room_drive", {31'h0, er != 3'h0}, {31'h0, room_lamp_drive});
    if (ef != 3'h3) chk("foot_drive", {31'h0, ef != 3'h0}, {31'h0, foot_lamp_drive});
  endtask : st

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 10000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b0, CTRL_OFS, 32'h0, rd);
    chk("ctrl_reset", {30'h0, CTRL_RST}, rd);
    bus(1'b0, 4'h8, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    st(4'h4, 4'hf, 3'h0, 20, 3'h2, 3'h2);
    st(4'hc, 4'hf, 3'h0, 20, 3'h4, 3'h4);
    st(4'h8, 4'hf, 3'h0, 20, 3'h3, 3'h3);
    st(4'hc, 4'hf, 3'h0, 20, 3'h4, 3'h4);
    st(4'h4, 4'hf, 3'h0, 20, 3'h2, 3'h2);
    st(4'h0, 4'hf, 3'h0, 20, 3'h1, 3'h1);
    st(4'h4, 4'hf, 3'h0, 20, 3'h2, 3'h2);
    st(4'hc, 4'hf, 3'h0, 20, 3'h4, 3'h4);
    st(4'h0, 4'hf, 3'h0, 20, 3'h1, 3'h1);
    st(4'h0, 4'h7, 3'h0, 20, 3'h1, 3'h1);
    st(4'h0, 4'h0, 3'h0, 20, 3'h3, 3'h3);
    st(4'h0, 4'hf, 3'h2, 20, 3'h1, 3'h1);
    st(4'h1, 4'hf, 3'h0, 20, 3'h3, 3'h3);
    st(4'h1, 4'hf, 3'h0, 560, 3'h0, 3'h0);
    st(4'h0, 4'hf, 3'h1, 80, 3'h1, 3'h1);
    st(4'h0, 4'hf, 3'h1, 80, 3'h1, 3'h1);
    st(4'h0, 4'hf, 3'h0, 80, 3'h3, 3'h3);
    skv <= 1'b0;
    st(4'h0, 4'hf, 3'h4, 20, 3'h3, 3'h3);
    skv <= 1'b1;
    st(4'h0, 4'hf, 3'h4, 20, 3'h1, 3'h1);
    st(4'h1, 4'hf, 3'h0, 580, 3'h0, 3'h0);
    st(4'ha, 4'hf, 3'h0, 20, 3'h0, 3'h4);
    bus(1'b1, CTRL_OFS, 32'h1, rd);
    st(4'ha, 4'hf, 3'h0, 20, 3'h0, 3'h0);
    bus(1'b0, CTRL_OFS, 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    avs_byteenable <= 4'h0;
    bus(1'b1, CTRL_OFS, 32'h3, rd);
    bus(1'b0, CTRL_OFS, 32'h0, rd);
    chk("ctrl_no_be", 32'h1, rd);
    final_report();
  end
endmodule : courtesy_lamp_fade_timer_tb
